// File: rtl/brd_baud_divider.sv
// What this block does
// - timer counts down, source chosen by divider enable
// - run bit acts only in prescaler and fractional modes
// - underflow reloads reload value, emits one pulse
// - normal divider mode stops baud timer
// - prescaler divides by two to select
// - fractional mode scales rate by step/256
// - baud rate is clock/prescale/(reload+1)
// - baud rate reaches clock with prescale one and reload zero
// - timer 1 overflow may clock serial instead
// - mode select one with divider enable stops baud timer
// - normal mode: 8-bit up-counting auto-reload timer
// - count output shows timer, step is reload
// - normal overflow sets flag, requests interrupt
// - normal output pulses every 256-step inputs
// - overflow interrupt shares vector with others
`timescale 1ns/1ns
`default_nettype none
module brd_baud_divider
	import brd_pkg::*;
(
	input  wire logic                          ref_clk,
	input  wire logic                          sys_rst,
	input  wire logic [brd_pkg::BRD_PRE_W-1:0]  baud_prescale_sel,
	input  wire logic                          baud_timer_go,
	input  wire logic [brd_pkg::BRD_BYTE_W-1:0] baud_reload_value,
	input  wire logic                          fracdiv_enable,
	input  wire logic                          fracdiv_mode_select,
	input  wire logic [brd_pkg::BRD_BYTE_W-1:0] fracdiv_increment_reg,
	input  wire logic                          ovf_flag_clear,
	input  wire logic                          timer1_baud_select,
	input  wire logic                          timer1_overflow,
	input  wire logic                          double_rate_select,
	output logic                               baud_tick,
	output logic                               divider_out_clock,
	output logic [brd_pkg::BRD_BYTE_W-1:0]      fracdiv_count_reg,
	output logic [brd_pkg::BRD_BYTE_W-1:0]      baud_count,
	output logic                               divider_overflow_flag,
	output logic                               divider_irq
);
	logic                  pre_tick;
	logic                  frac_carry;
	logic                  norm_ovf;
	logic                  norm_run;
	logic                  timer_clk;
	logic                  timer_run;
	logic                  timer_under;
	logic                  t1_half;
	logic                  t1_tick;
	logic [BRD_BYTE_W:0]   frac_sum;
	logic [BRD_BYTE_W-1:0] next_fracdiv_count;
	logic [BRD_BYTE_W-1:0] next_baud_count;
	logic                  next_baud_tick;
	brd_src_e              src;

	brd_prescaler u_pre (
		.ref_clk          (ref_clk),
		.sys_rst          (sys_rst),
		.baud_prescale_sel(baud_prescale_sel),
		.pre_tick         (pre_tick)
	);

	// source selection
	always_comb begin
		if (!fracdiv_enable)
			src = BRD_SRC_PRE;
		else if (fracdiv_mode_select)
			src = BRD_SRC_NORM;
		else
			src = BRD_SRC_FRAC;
	end

	// accumulator sum with carry bit
	assign frac_sum   = {1'b0, fracdiv_count_reg} + {1'b0, fracdiv_increment_reg};
	assign frac_carry = pre_tick && (src == BRD_SRC_FRAC) && frac_sum[BRD_BYTE_W];

	// normal mode already running; its first cycle loads the reload value
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			norm_run <= 1'b0;
		else
			norm_run <= (src == BRD_SRC_NORM);
	end

	// normal overflow only once counting has started
	assign norm_ovf = pre_tick && (src == BRD_SRC_NORM) && norm_run
		&& (fracdiv_count_reg == BRD_BYTE_MAX);

	// baud timer clock source
	assign timer_clk = (src == BRD_SRC_PRE) ? pre_tick : frac_carry;
	// run bit gated off in normal mode
	assign timer_run = baud_timer_go && (src != BRD_SRC_NORM);

	// shared divider count next value
	always_comb begin
		next_fracdiv_count = fracdiv_count_reg;
		case (src)
			BRD_SRC_FRAC: begin
				if (pre_tick)
					next_fracdiv_count = frac_sum[BRD_BYTE_W-1:0];
			end
			BRD_SRC_NORM: begin
				if (!norm_run)
					next_fracdiv_count = fracdiv_increment_reg;
				else if (norm_ovf)
					next_fracdiv_count = fracdiv_increment_reg;
				else if (pre_tick)
					next_fracdiv_count = fracdiv_count_reg + BRD_BYTE_ONE;
			end
			default: begin
				next_fracdiv_count = fracdiv_count_reg;
			end
		endcase
	end

	// shared divider count register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			fracdiv_count_reg <= BRD_BYTE_ZERO;
		else
			fracdiv_count_reg <= next_fracdiv_count;
	end

	// divider output pulse
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			divider_out_clock <= 1'b0;
		else
			divider_out_clock <= frac_carry || norm_ovf;
	end

	// overflow flag, set wins over clear
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			divider_overflow_flag <= 1'b0;
		else if (norm_ovf)
			divider_overflow_flag <= 1'b1;
		else if (ovf_flag_clear)
			divider_overflow_flag <= 1'b0;
	end

	// interrupt request pulse, routed to shared vector outside
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			divider_irq <= 1'b0;
		else
			divider_irq <= norm_ovf;
	end

	// underflow of the baud reload timer
	assign timer_under = timer_run && timer_clk && (baud_count == BRD_BYTE_ZERO);

	// baud reload timer next value, counts down
	always_comb begin
		next_baud_count = baud_count;
		if (timer_under)
			next_baud_count = baud_reload_value;
		else if (timer_run && timer_clk)
			next_baud_count = baud_count - BRD_BYTE_ONE;
	end

	// baud reload timer register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			baud_count <= BRD_BYTE_ZERO;
		else
			baud_count <= next_baud_count;
	end

	// timer 1 overflow halved for serial modes 1 and 3
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			t1_half <= 1'b0;
		else if (timer1_overflow)
			t1_half <= ~t1_half;
	end

	// every second timer 1 overflow unless double rate
	assign t1_tick = timer1_overflow && (double_rate_select || t1_half);

	// serial channel clock source
	always_comb begin
		if (timer1_baud_select)
			next_baud_tick = t1_tick;
		else
			next_baud_tick = timer_under;
	end

	// serial channel clock pulse
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			baud_tick <= 1'b0;
		else
			baud_tick <= next_baud_tick;
	end
endmodule : brd_baud_divider
`default_nettype wire

// File: rtl/brd_pkg.sv
package brd_pkg;
	localparam int          BRD_CLK_HZ      = 10000000;
	localparam int          BRD_PRE_W       = 3;
	localparam int          BRD_BYTE_W      = 8;
	localparam int          BRD_PRE_CNT_W   = 8;
	localparam int          BRD_OVS_DIV     = 16;
	localparam int          BRD_MAX_DIV     = 32;
	localparam int          BRD_FRAC_DEN    = 256;
	localparam logic [7:0]  BRD_BYTE_ZERO   = 8'h00;
	localparam logic [7:0]  BRD_BYTE_ONE    = 8'h01;
	localparam logic [7:0]  BRD_BYTE_MAX    = 8'hff;
	localparam logic [7:0]  BRD_PRE_ZERO    = 8'h00;
	localparam logic [2:0]  BRD_PRE_MAX_SEL = 3'h7;
	localparam logic [3:0]  BRD_T1_MODE_AR  = 4'h2;
	typedef enum logic [1:0] {
		BRD_SRC_PRE  = 2'b00,
		BRD_SRC_FRAC = 2'b01,
		BRD_SRC_NORM = 2'b10
	} brd_src_e;
endpackage : brd_pkg

// File: rtl/brd_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module brd_prescaler
	import brd_pkg::*;
(
	input  wire logic                     ref_clk,
	input  wire logic                     sys_rst,
	input  wire logic [brd_pkg::BRD_PRE_W-1:0] baud_prescale_sel,
	output logic                          pre_tick
);
	logic [BRD_PRE_CNT_W-1:0] count;
	logic [BRD_PRE_CNT_W-1:0] limit;

	// divide by two to the select field
	assign limit = BRD_PRE_CNT_W'((BRD_BYTE_ONE << baud_prescale_sel) - BRD_BYTE_ONE);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			count    <= BRD_PRE_ZERO;
			pre_tick <= 1'b0;
		end else if (count >= limit) begin
			count    <= BRD_PRE_ZERO;
			pre_tick <= 1'b1;
		end else begin
			count    <= count + BRD_BYTE_ONE;
			pre_tick <= 1'b0;
		end
	end
endmodule : brd_prescaler
`default_nettype wire

// File: tb/brd_serial_model.sv
`timescale 1ns/1ns
`default_nettype none
module brd_serial_model (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic baud_tick,
	output var int   ticks
);
	// channel counts bit-clock pulses
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			ticks <= 0;
		else if (baud_tick === 1'b1)
			ticks <= ticks + 1;
	end
endmodule : brd_serial_model
`default_nettype wire

// File: tb/brd_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module brd_checker (
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic       baud_timer_go,
	input wire logic [7:0] baud_reload_value,
	input wire logic       fracdiv_enable,
	input wire logic       fracdiv_mode_select,
	input wire logic [7:0] fracdiv_increment_reg,
	input wire logic       ovf_flag_clear,
	input wire logic       timer1_baud_select,
	input wire logic       timer1_overflow,
	input wire logic       baud_tick,
	input wire logic       divider_out_clock,
	input wire logic [7:0] fracdiv_count_reg,
	input wire logic [7:0] baud_count,
	input wire logic       divider_overflow_flag,
	input wire logic       divider_irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	norm_stop_a: assert property ((fracdiv_enable && fracdiv_mode_select && !timer1_baud_select) [*3] |-> !baud_tick)
		else $error("tick in normal mode");
	run_hold_a: assert property ((!baud_timer_go && !timer1_baud_select) [*3] |-> !baud_tick && $stable(baud_count))
		else $error("timer moved while stopped");
	reload_value_a: assert property (baud_tick && !$past(timer1_baud_select) |-> baud_count == $past(baud_reload_value))
		else $error("bad reload");
	count_down_a: assert property ($changed(baud_count) && !baud_tick && !$past(timer1_baud_select)
		|-> baud_count == $past(baud_count) - 8'h01)
		else $error("bad count step");
	norm_reload_a: assert property (divider_irq |-> fracdiv_count_reg == $past(fracdiv_increment_reg))
		else $error("normal timer not reloaded");
	t1_tick_a: assert property ($past(timer1_baud_select) && baud_tick |-> $past(timer1_overflow))
		else $error("tick without timer 1 overflow");
	irq_flag_a: assert property (divider_irq |-> divider_overflow_flag)
		else $error("irq without flag");
	irq_out_a: assert property (divider_irq |-> divider_out_clock)
		else $error("irq without pulse");
	irq_mode_a: assert property (divider_irq |-> $past(fracdiv_enable && fracdiv_mode_select))
		else $error("irq outside normal mode");
	flag_clr_a: assert property ($fell(divider_overflow_flag) |-> $past(ovf_flag_clear))
		else $error("flag lost");
	cover property (baud_tick);
	cover property (divider_irq);
	cover property ($fell(divider_overflow_flag));
	cover property (timer1_baud_select && baud_tick);
endmodule : brd_checker
bind brd_baud_divider brd_checker chk (
	.ref_clk              (ref_clk),
	.sys_rst              (sys_rst),
	.baud_timer_go        (baud_timer_go),
	.baud_reload_value    (baud_reload_value),
	.fracdiv_enable       (fracdiv_enable),
	.fracdiv_mode_select  (fracdiv_mode_select),
	.fracdiv_increment_reg(fracdiv_increment_reg),
	.ovf_flag_clear       (ovf_flag_clear),
	.timer1_baud_select   (timer1_baud_select),
	.timer1_overflow      (timer1_overflow),
	.baud_tick            (baud_tick),
	.divider_out_clock    (divider_out_clock),
	.fracdiv_count_reg    (fracdiv_count_reg),
	.baud_count           (baud_count),
	.divider_overflow_flag(divider_overflow_flag),
	.divider_irq          (divider_irq)
);
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic       clk = 1'b0, rst = 1'b1, go = 1'b0, en = 1'b0, md = 1'b0, clr = 1'b0, bt, dc, fl, irq;
	logic       t1s = 1'b0, t1o = 1'b0, dbl = 1'b0;
	logic [2:0] sel = 3'h0;
	logic [7:0] rl = 8'h00, st = 8'h00, bc, fc;
	int         ticks, num_errors = 0, compares = 0;
	brd_baud_divider dut (.ref_clk(clk), .sys_rst(rst), .baud_prescale_sel(sel), .baud_timer_go(go),
		.baud_reload_value(rl), .fracdiv_enable(en), .fracdiv_mode_select(md), .fracdiv_increment_reg(st),
		.ovf_flag_clear(clr), .timer1_baud_select(t1s), .timer1_overflow(t1o), .double_rate_select(dbl),
		.baud_tick(bt), .divider_out_clock(dc), .fracdiv_count_reg(fc), .baud_count(bc),
		.divider_overflow_flag(fl), .divider_irq(irq));
	brd_serial_model chan (.ref_clk(clk), .sys_rst(rst), .baud_tick(bt), .ticks(ticks));
	initial forever #50 clk = ~clk;
	task chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %0d want %0d", $time, got, exp);
		end
	endtask : chk
	task summarize;
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task run(input logic [2:0] s, input logic [7:0] r, t, input logic [2:0] gem, input int eb, ed);
		int t0;
		int dn;
		int dq;
		int fb;
		@(posedge clk);
		sel <= s;
		rl <= r;
		st <= t;
		{go, en, md} <= gem;
		repeat (40) @(posedge clk);
		t0 = ticks;
		dn = 0;
		dq = 0;
		fb = 0;
		repeat (60) begin
			@(posedge clk);
			if (dc === 1'b1)
				dn++;
			if (irq === 1'b1)
				dq++;
			if (dc === 1'b1 && gem[1:0] === 2'b11 && fc !== t)
				fb++;
		end
		chk(ticks - t0, eb);
		chk(dn, ed);
		chk(dq, (gem[1:0] === 2'b11) ? ed : 0);
		chk(fb, 0);
		$display("test done sel %0d reload %0d", s, r);
	endtask : run
	task t1run(input logic d, input int exp);
		int t0;
		@(posedge clk);
		t1s <= 1'b1;
		dbl <= d;
		repeat (3) @(posedge clk);
		t0 = ticks;
		repeat (16) begin
			t1o <= 1'b1;
			@(posedge clk);
			t1o <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (4) @(posedge clk);
		chk(ticks - t0, exp);
		t1s <= 1'b0;
		$display("test done timer1 double %0d", d);
	endtask : t1run
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		chk(int'(fl === 1'b0), 1);
		run(3'h0, 8'h01, 8'h00, 3'b100, 30, 0);
		run(3'h1, 8'h02, 8'h00, 3'b100, 10, 0);
		run(3'h2, 8'h00, 8'h00, 3'b100, 15, 0);
		run(3'h0, 8'h01, 8'h00, 3'b000, 0, 0);
		run(3'h0, 8'h01, 8'h80, 3'b110, 15, 30);
		run(3'h0, 8'h01, 8'hfc, 3'b111, 0, 15);
		chk(int'(fl === 1'b1), 1);
		en <= 1'b0;
		clr <= 1'b1;
		repeat (2) @(posedge clk);
		clr <= 1'b0;
		repeat (2) @(posedge clk);
		chk(int'(fl === 1'b0), 1);
		$display("test done overflow flag");
		t1run(1'b0, 8);
		t1run(1'b1, 16);
		summarize();
	end
endmodule : testbench
`default_nettype wire
